// >>> lsch_pkg.sv
// Constants, types and character codes for the laser serial command handler
// How it works
// - Frames carry a two-digit decimal unit number, tens character then units character.
// - Start command answers ACK when ready to fire, otherwise NAK.
// - Not ready on any alarm, high voltage off, uncharged, or not host control.
// - An accepted stop command ends laser output.
// - Stop, error clear, lamp and crystal resets need host control, else NAK.
// - Host link control is control method value two.
// - An accepted error clear drops the error signal output, unless a fault is still present.
// - An accepted lamp reset clears the lamp total counter.
// - Good-count reset clears the counter of good shots.
// - An accepted crystal reset clears the crystal usage counter.
// - Fault read replies with fault code digits, tens first then units.
// - Fault read reports every fault code present, not only the first.
// - With no fault present the fault read reports zero-zero.
// - Interlock faults carry their own codes.
// - Coolant faults and the resistivity caution carry distinct codes.
// - Power path faults carry distinct codes.
// - Setting and limit violations carry distinct codes.
// - Component faults carry distinct codes.
`default_nettype none
package lsch_pkg;
	// Link characters
	localparam logic [7:0] CH_STX   = 8'h02;
	localparam logic [7:0] CH_ETX   = 8'h03;
	localparam logic [7:0] CH_ACK   = 8'h06;
	localparam logic [7:0] CH_NAK   = 8'h15;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_DOLR  = 8'h24;
	localparam logic [7:0] CH_NINE  = 8'h39;
	localparam logic [7:0] CH_ONE   = 8'h31;
	localparam logic [7:0] CH_TWO   = 8'h32;
	localparam logic [7:0] CH_THREE = 8'h33;
	localparam logic [7:0] CH_C     = 8'h43;
	localparam logic [7:0] CH_R     = 8'h52;
	localparam logic [7:0] CH_T     = 8'h54;
	// Control method value for host link control
	localparam logic [2:0] METHOD_HOST = 3'h2;
	// Assigned fault codes; bit 0 is normal and never a fault
	localparam logic [63:0] CODE_MASK = 64'h0b7ff0df_e019fd1e;
	localparam logic [5:0]  CODE_LAST = 6'h3f;
	// Wishbone byte offsets
	localparam logic [7:0] ADR_UNIT   = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_LAMP   = 8'h08;
	localparam logic [7:0] ADR_GOOD   = 8'h0c;
	localparam logic [7:0] ADR_CRYST  = 8'h10;
	localparam logic [7:0] UNIT_RST   = 8'h00;
	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} lsch_wb_req_t;
	// Status word read back by software
	typedef struct packed {
		logic       laserOn;
		logic       errSig;
		logic       ready;
		logic [2:0] method;
	} lsch_stat_t;
	// Decoded host commands
	typedef enum {
		CMD_NONE, CMD_START, CMD_STOP, CMD_CLRERR,
		CMD_RSTLAMP, CMD_RSTGOOD, CMD_RSTCRY, CMD_READERR
	} lsch_cmd_t;
endpackage
`default_nettype wire

// >>> lsch_handler.sv
// Laser serial command handler: frame receiver, command execution, replies, counters
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module lsch_handler
	import lsch_pkg::*;
(
	// Clock, reset, enable
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Wishbone slave
	input  wire lsch_wb_req_t wbReq,
	output logic [31:0]       wbDatO,
	output logic              wbAck,
	// Host link characters in
	input  wire logic [7:0]   rxData,
	input  wire logic         rxValid,
	output logic              rxReady,
	// Host link characters out
	output logic [7:0]        txData,
	output logic              txValid,
	input  wire logic         txReady,
	// Laser state
	input  wire logic [63:0]  faults,
	input  wire logic         highVoltageOn,
	input  wire logic         charged,
	input  wire logic [2:0]   controlMethod,
	input  wire logic         shotPulse,
	input  wire logic         goodPulse,
	// Laser outputs
	output logic              laserEnable,
	output logic              errorSignal
);
	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic lsch_cmd_t cmdOf(input logic [7:0] a, input logic [7:0] b);
		cmdOf = CMD_NONE;
		if (a == CH_DOLR && b == CH_ZERO) cmdOf = CMD_START;
		if (a == CH_DOLR && b == CH_NINE) cmdOf = CMD_STOP;
		if (a == CH_C && b == CH_ZERO) cmdOf = CMD_CLRERR;
		if (a == CH_C && b == CH_ONE) cmdOf = CMD_RSTLAMP;
		if (a == CH_C && b == CH_TWO) cmdOf = CMD_RSTGOOD;
		if (a == CH_C && b == CH_THREE) cmdOf = CMD_RSTCRY;
		if (a == CH_R && b == CH_T) cmdOf = CMD_READERR;
	endfunction
	function automatic logic [7:0] asciiTens(input logic [5:0] c);
		asciiTens = CH_ZERO + 8'(c / 6'd10);
	endfunction
	function automatic logic [7:0] asciiUnits(input logic [5:0] c);
		asciiUnits = CH_ZERO + 8'(c % 6'd10);
	endfunction
	// ****************************************
	// Declarations
	// ****************************************
	typedef enum {R_IDLE, R_U1, R_U0, R_K1, R_K0, R_ETX, R_BCC} lsch_rx_t;
	typedef enum {T_IDLE, T_ACK, T_STX, T_U1, T_U0, T_R, T_T, T_SCAN,
		T_E1, T_E0, T_ETX, T_BCC} lsch_tx_t;
	lsch_rx_t    rxSt_r;
	lsch_tx_t    txSt_r, txSt_nxt;
	logic [7:0]  rxU1_r, rxU0_r, k1_r, k0_r, rxBcc_r, txBcc_r;
	logic [7:0]  unitNum_r, txData_r, byteNxt;
	logic        txValid_r, load, ackFlag_r, laser_r, errSig_r, ack_r;
	logic [31:0] lampCnt_r, goodCnt_r, crystCnt_r, wbDat_r, rdMux;
	logic [63:0] snap_r;
	logic [5:0]  idx_r, codeSel_r;
	logic        found_r;
	logic        rxTake, canLoad, unitHit, exec, alarm, hostMode, ready, accept;
	lsch_cmd_t   cmd;
	lsch_stat_t  stat;
	// Readiness and mode
	assign hostMode = (controlMethod == METHOD_HOST);
	assign alarm    = |(faults & CODE_MASK);
	assign ready    = !alarm && highVoltageOn && charged && hostMode;
	assign stat     = '{laserOn: laser_r, errSig: errSig_r, ready: ready,
		method: controlMethod};
	// ****************************************
	// Frame receiver
	// ****************************************
	// Characters are refused while a reply is in progress
	assign rxReady = (txSt_r == T_IDLE);
	assign rxTake  = ce && rxValid && rxReady;
	assign cmd     = cmdOf(k1_r, k0_r);
	assign unitHit = (rxU1_r == {4'h3, unitNum_r[7:4]})
		&& (rxU0_r == {4'h3, unitNum_r[3:0]});
	// Only a frame with a good check and our unit number executes
	assign exec    = rxTake && rxSt_r == R_BCC && rxData == rxBcc_r && unitHit;
	// Receive state and field capture; STX restarts the frame anywhere except in the check character position
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			rxSt_r  <= R_IDLE;
			rxU1_r  <= 8'h00;
			rxU0_r  <= 8'h00;
			k1_r    <= 8'h00;
			k0_r    <= 8'h00;
			rxBcc_r <= 8'h00;
		end
		else if (rxTake)
		begin
			rxBcc_r <= rxBcc_r ^ rxData;
			case (rxSt_r)
				R_U1:    begin rxU1_r <= rxData; rxSt_r <= R_U0; end
				R_U0:    begin rxU0_r <= rxData; rxSt_r <= R_K1; end
				R_K1:    begin k1_r <= rxData; rxSt_r <= R_K0; end
				R_K0:    begin k0_r <= rxData; rxSt_r <= R_ETX; end
				R_ETX:   rxSt_r <= (rxData == CH_ETX) ? R_BCC : R_IDLE;
				default: rxSt_r <= R_IDLE;
			endcase
			if (rxData == CH_STX && rxSt_r != R_BCC)
			begin
				rxSt_r  <= R_U1;
				rxBcc_r <= 8'h00;
			end
		end
	// ****************************************
	// Command execution
	// ****************************************
	always_comb
	begin
		case (cmd)
			CMD_START:   accept = ready;
			CMD_STOP, CMD_CLRERR, CMD_RSTLAMP, CMD_RSTCRY: accept = hostMode;
			CMD_RSTGOOD, CMD_READERR: accept = 1'b1;
			default:     accept = 1'b0;
		endcase
	end
	// Answer flag and laser enable
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			ackFlag_r <= 1'b0;
			laser_r   <= 1'b0;
		end
		else if (ce && exec)
		begin
			ackFlag_r <= accept;
			if (cmd == CMD_START && accept)
				laser_r <= 1'b1;
			if (cmd == CMD_STOP && accept)
				laser_r <= 1'b0;
		end
	// Error signal: a present fault keeps it set even against a clear
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			errSig_r <= 1'b0;
		else if (ce)
			errSig_r <= alarm || (errSig_r && !(exec && cmd == CMD_CLRERR && accept));
	// Counters; a shot arriving in the clearing cycle still counts
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			lampCnt_r  <= 32'h0;
			goodCnt_r  <= 32'h0;
			crystCnt_r <= 32'h0;
		end
		else if (ce)
		begin
			lampCnt_r  <= ((exec && cmd == CMD_RSTLAMP && accept) ? 32'h0 : lampCnt_r)
				+ {31'h0, shotPulse};
			goodCnt_r  <= ((exec && cmd == CMD_RSTGOOD) ? 32'h0 : goodCnt_r)
				+ {31'h0, goodPulse};
			crystCnt_r <= ((exec && cmd == CMD_RSTCRY && accept) ? 32'h0 : crystCnt_r)
				+ {31'h0, shotPulse};
		end
	// ****************************************
	// Reply transmitter
	// ****************************************
	assign canLoad = !txValid_r || txReady;
	always_comb
	begin
		txSt_nxt = txSt_r;
		load     = 1'b1;
		byteNxt  = 8'h00;
		case (txSt_r)
			T_IDLE:
			begin
				load = 1'b0;
				if (exec)
					txSt_nxt = (cmd == CMD_READERR) ? T_STX : T_ACK;
			end
			T_ACK: begin byteNxt = ackFlag_r ? CH_ACK : CH_NAK; txSt_nxt = T_IDLE; end
			T_STX: begin byteNxt = CH_STX; txSt_nxt = T_U1; end
			T_U1:  begin byteNxt = {4'h3, unitNum_r[7:4]}; txSt_nxt = T_U0; end
			T_U0:  begin byteNxt = {4'h3, unitNum_r[3:0]}; txSt_nxt = T_R; end
			T_R:   begin byteNxt = CH_R; txSt_nxt = T_T; end
			T_T:   begin byteNxt = CH_T; txSt_nxt = T_SCAN; end
			T_SCAN:
			begin
				load = 1'b0;
				if (snap_r[idx_r])
					txSt_nxt = T_E1;
				else if (idx_r == CODE_LAST)
					txSt_nxt = found_r ? T_ETX : T_E1;
			end
			T_E1:  begin byteNxt = asciiTens(codeSel_r); txSt_nxt = T_E0; end
			T_E0:
			begin
				byteNxt  = asciiUnits(codeSel_r);
				txSt_nxt = (codeSel_r == 6'h0 || idx_r == CODE_LAST) ? T_ETX : T_SCAN;
			end
			T_ETX: begin byteNxt = CH_ETX; txSt_nxt = T_BCC; end
			T_BCC: begin byteNxt = txBcc_r; txSt_nxt = T_IDLE; end
			default: begin load = 1'b0; txSt_nxt = T_IDLE; end
		endcase
		// Hold the state while the link has not taken the last character
		if (load && !canLoad)
		begin
			load     = 1'b0;
			txSt_nxt = txSt_r;
		end
	end
	// Output character register and reply check character
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			txSt_r    <= T_IDLE;
			txData_r  <= 8'h00;
			txValid_r <= 1'b0;
			txBcc_r   <= 8'h00;
		end
		else if (ce)
		begin
			txSt_r <= txSt_nxt;
			if (load)
			begin
				txData_r  <= byteNxt;
				txValid_r <= 1'b1;
				txBcc_r   <= (txSt_r == T_STX) ? 8'h00 : txBcc_r ^ byteNxt;
			end
			else if (txReady)
				txValid_r <= 1'b0;
		end
	// Fault scan: snapshot at command time so the list is self-consistent
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			snap_r    <= 64'h0;
			idx_r     <= 6'h1;
			codeSel_r <= 6'h0;
			found_r   <= 1'b0;
		end
		else if (ce)
		begin
			if (exec)
			begin
				snap_r  <= faults & CODE_MASK;
				idx_r   <= 6'h1;
				found_r <= 1'b0;
			end
			else if (txSt_r == T_SCAN)
			begin
				if (snap_r[idx_r])
				begin
					codeSel_r <= idx_r;
					found_r   <= 1'b1;
				end
				else if (idx_r == CODE_LAST)
					codeSel_r <= 6'h0;
				else
					idx_r <= idx_r + 6'h1;
			end
			else if (txSt_r == T_E0 && load && txSt_nxt == T_SCAN)
				idx_r <= idx_r + 6'h1;
		end
	// ****************************************
	// Wishbone slave
	// ****************************************
	always_comb
	begin
		case (wbReq.adr)
			ADR_UNIT:   rdMux = {24'h0, unitNum_r};
			ADR_STATUS: rdMux = {26'h0, stat};
			ADR_LAMP:   rdMux = lampCnt_r;
			ADR_GOOD:   rdMux = goodCnt_r;
			ADR_CRYST:  rdMux = crystCnt_r;
			default:    rdMux = 32'h0;
		endcase
	end
	// One wait state: ack follows the request by one edge, unmapped reads zero
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			ack_r     <= 1'b0;
			wbDat_r   <= 32'h0;
			unitNum_r <= UNIT_RST;
		end
		else if (ce)
		begin
			ack_r   <= wbReq.cyc && wbReq.stb && !ack_r;
			wbDat_r <= rdMux;
			if (wbReq.cyc && wbReq.stb && !ack_r && wbReq.we
				&& wbReq.sel[0] && wbReq.adr == ADR_UNIT)
				unitNum_r <= wbReq.dat[7:0];
		end
	assign wbAck       = ack_r;
	assign wbDatO      = wbDat_r;
	assign txData      = txData_r;
	assign txValid     = txValid_r;
	assign laserEnable = laser_r;
	assign errorSignal = errSig_r;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_exec(lsch_cmd_t c);
		exec && cmd == c;
	endsequence
	sequence s_ackAnswer;
		txSt_r == T_ACK ##[0:40] (load && txSt_r == T_ACK);
	endsequence
	property p_foreign;
		(rxTake && rxSt_r == R_BCC && !unitHit) |=> txSt_r == T_IDLE;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign frame answered");
	property p_startAck;
		(s_exec(CMD_START) and ready) |=> ackFlag_r && laser_r ##0 s_ackAnswer;
	endproperty
	a_startAck: assert property (p_startAck) else $error("start not acknowledged");
	property p_startNak;
		(s_exec(CMD_START) and !ready) |=> !ackFlag_r && $stable(laser_r);
	endproperty
	a_startNak: assert property (p_startNak) else $error("start accepted unready");
	property p_stop;
		(s_exec(CMD_STOP) and hostMode) |=> !laser_r;
	endproperty
	a_stop: assert property (p_stop) else $error("laser still enabled after stop");
	property p_nonHost;
		(exec && !hostMode && (cmd == CMD_STOP || cmd == CMD_CLRERR
			|| cmd == CMD_RSTLAMP || cmd == CMD_RSTCRY)) |=> !ackFlag_r;
	endproperty
	a_nonHost: assert property (p_nonHost) else $error("command accepted off host");
	property p_errClr;
		(s_exec(CMD_CLRERR) and hostMode && !alarm) |=> !errorSignal;
	endproperty
	a_errClr: assert property (p_errClr) else $error("error signal not cleared");
	property p_lampClr;
		(s_exec(CMD_RSTLAMP) and hostMode && !shotPulse) |=> lampCnt_r == 32'h0;
	endproperty
	a_lampClr: assert property (p_lampClr) else $error("lamp counter not cleared");
	property p_goodClr;
		(s_exec(CMD_RSTGOOD) and !goodPulse) |=> goodCnt_r == 32'h0;
	endproperty
	a_goodClr: assert property (p_goodClr) else $error("good counter not cleared");
	property p_crystClr;
		(s_exec(CMD_RSTCRY) and hostMode && !shotPulse) |=> crystCnt_r == 32'h0;
	endproperty
	a_crystClr: assert property (p_crystClr) else $error("crystal counter not cleared");
	property p_tens;
		(load && txSt_r == T_E1) |=> txData_r == asciiTens(codeSel_r);
	endproperty
	a_tens: assert property (p_tens) else $error("wrong tens digit");
	property p_zero;
		(ce && txSt_r == T_SCAN && idx_r == CODE_LAST && !found_r && !snap_r[idx_r])
			|=> txSt_r == T_E1 && codeSel_r == 6'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("normal not reported");
	property p_reserved;
		(txSt_r == T_E1) |-> (codeSel_r == 6'h0 || CODE_MASK[codeSel_r]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code reported");
endmodule
`default_nettype wire

// >>> lsch_host.sv
// Host link model: sends command frames and gathers reply characters
`timescale 1ns/1ns
`default_nettype none
module lsch_host
	import lsch_pkg::*;
(
	// Clock and pacing
	input  wire logic       mclk,
	input  wire logic       slow,
	// Characters to the handler
	output logic [7:0]      rxData,
	output logic            rxValid,
	input  wire logic       rxReady,
	// Characters from the handler
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	output logic            txReady
);
	// ****
	// Link side
	// ****
	logic [7:0] reply[$];
	logic [1:0] pace_r = 2'h0;
	initial rxData = 8'h00;
	initial rxValid = 1'b0;
	// Slow mode takes one reply character in four, to stall the sender
	always_ff @(posedge mclk)
		pace_r <= pace_r + 2'h1;
	assign txReady = !slow || pace_r == 2'h0;
	// Gather reply characters as they are taken
	always @(posedge mclk)
		if (txValid && txReady)
			reply.push_back(txData);
	// One character, held until the edge that sees rxReady high
	task automatic put(input logic [7:0] b);
		rxData <= b;
		rxValid <= 1'b1;
		do @(negedge mclk); while (!rxReady);
		@(posedge mclk);
	endtask
	// Whole frame; bad spoils the check character
	task automatic frame(input logic [7:0] u, input logic [7:0] k1,
		input logic [7:0] k0, input logic bad);
		logic [7:0] f[6];
		logic [7:0] x;
		f = '{CH_STX, CH_ZERO | {4'h0, u[7:4]}, CH_ZERO | {4'h0, u[3:0]}, k1, k0, CH_ETX};
		x = {7'h0, bad};
		@(posedge mclk);
		foreach (f[i])
		begin
			put(f[i]);
			if (i > 0)
				x = x ^ f[i];
		end
		put(x);
		rxValid <= 1'b0;
		rxData <= ~x; // Released line shows the inverse, never a stale match
	endtask
endmodule
`default_nettype wire

// >>> lsch_handler_bench.sv
// Self-checking bench for the laser serial command handler
`timescale 1ns/1ns
`default_nettype none
module lsch_handler_bench
	import lsch_pkg::*;
;
	// ****
	// Signals and helpers
	// ****
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	lsch_wb_req_t wbReq = '0;
	logic [31:0]  wbDatO, rd;
	logic         wbAck, rxReady, txValid, txReady, rxValid, laserEnable, errorSignal;
	logic [7:0]   rxData, txData, unit;
	logic [63:0]  faults = '0;
	logic         hv = 1'b0, chg = 1'b0, shot = 1'b0, good = 1'b0, slow = 1'b0;
	logic [2:0]   meth = 3'h0;
	logic [15:0]  lfsr = 16'h0013;
	logic [7:0]   expQ[$];
	int           failCount = 0, checks = 0, cycles = 0, nShot = 0, nGood = 0;
	initial
		forever #20 mclk = ~mclk;
	lsch_handler dut (.mclk(mclk), .rst(rst), .ce(1'b1), .wbReq(wbReq), .wbDatO(wbDatO),
		.wbAck(wbAck), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
		.txValid(txValid), .txReady(txReady), .faults(faults), .highVoltageOn(hv),
		.charged(chg), .controlMethod(meth), .shotPulse(shot), .goodPulse(good),
		.laserEnable(laserEnable), .errorSignal(errorSignal));
	lsch_host host (.mclk(mclk), .slow(slow), .rxData(rxData), .rxValid(rxValid),
		.rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady));
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			failCount++;
			$display("wrong value %s expected %h seen %h", n, want, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog far above the thousand or so cycles the run needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failCount++;
			end_of_test();
		end
	end
	// Classic single Wishbone cycle; read data taken with the ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
		// Ack and read data are taken at the rising edge that sees ack high
		do @(posedge mclk); while (wbAck !== 1'b1);
		rd = wbDatO;
		wbReq.cyc <= 1'b0;
		wbReq.stb <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] want, input string n);
		wb(1'b0, a, 32'h0);
		check(n, rd, want);
	endtask
	// Bounded by the watchdog, since reply length varies with the faults
	task automatic wait_reply(input int n);
		while (host.reply.size() < n)
			@(negedge mclk);
	endtask
	task automatic cmd(input logic [7:0] k1, input logic [7:0] k0, input logic [7:0] want);
		host.frame(unit, k1, k0, 1'b0);
		wait_reply(1);
		check("reply", {24'h0, host.reply.pop_front()}, {24'h0, want});
	endtask
	// Expected fault read reply: codes ascending, two digits each
	function automatic void rt_exp(input logic [63:0] f);
		logic [7:0] x;
		expQ = '{CH_STX, CH_ZERO | {4'h0, unit[7:4]}, CH_ZERO | {4'h0, unit[3:0]}, CH_R, CH_T};
		for (int c = 1; c < 64; c++)
			if (f[c] && CODE_MASK[c])
			begin
				expQ.push_back(CH_ZERO + 8'(c / 10));
				expQ.push_back(CH_ZERO + 8'(c % 10));
			end
		if (expQ.size() == 5)
			expQ = {expQ, CH_ZERO, CH_ZERO};
		expQ.push_back(CH_ETX);
		x = 8'h00;
		for (int i = 1; i < expQ.size(); i++)
			x = x ^ expQ[i];
		expQ.push_back(x);
	endfunction
	task automatic rt_run;
		host.frame(unit, CH_R, CH_T, 1'b0);
		rt_exp(faults);
		wait_reply(expQ.size());
		foreach (expQ[i])
			check("fault read", {24'h0, host.reply.pop_front()}, {24'h0, expQ[i]});
	endtask
	// Random shot train, roughly half judged good
	task automatic pulses(input int n);
		repeat (n)
		begin
			lfsr = step(lfsr);
			@(posedge mclk);
			shot <= 1'b1;
			good <= lfsr[0];
			nGood += lfsr[0];
			@(posedge mclk);
			shot <= 1'b0;
			good <= 1'b0;
		end
		nShot += n;
	endtask
	// ****
	// Scenarios
	// ****
	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		check("laser", laserEnable, 1'b0);
		check("rxReady", rxReady, 1'b1);
		rdchk(ADR_UNIT, 32'h0, "unit");
		lfsr = step(lfsr);
		unit = {4'(lfsr[3:0] % 10), 4'(lfsr[7:4] % 10)};
		wb(1'b1, ADR_UNIT, {24'h0, unit});
		rdchk(ADR_UNIT, {24'h0, unit}, "unit");
		rdchk(8'h20, 32'h0, "unmapped");
		$display("test registers done");
		@(posedge mclk);
		hv <= 1'b1;
		chg <= 1'b1;
		meth <= METHOD_HOST;
		rdchk(ADR_STATUS, 32'h0a, "status");
		cmd(CH_DOLR, CH_ZERO, CH_ACK);
		check("laser", laserEnable, 1'b1);
		cmd(CH_DOLR, CH_NINE, CH_ACK);
		check("laser", laserEnable, 1'b0);
		// Each not-ready cause alone refuses a start
		for (int i = 0; i < 4; i++)
		begin
			@(posedge mclk);
			hv <= i != 0;
			chg <= i != 1;
			meth <= i == 2 ? 3'h0 : METHOD_HOST;
			faults <= i == 3 ? 64'h2 : 64'h0;
			cmd(CH_DOLR, CH_ZERO, CH_NAK);
			check("laser", laserEnable, 1'b0);
		end
		$display("test start stop done");
		// Drop the fault left by the last not-ready case so only the latch holds the error
		@(posedge mclk);
		faults <= 64'h0;
		pulses(5 + lfsr[2:0]);
		// Every other control method refuses, with the far side stalling
		for (int m = 0; m < 8; m++)
			if (m != 2)
			begin
				@(posedge mclk);
				meth <= 3'(m);
				slow <= 1'b1;
				cmd(CH_DOLR, CH_NINE, CH_NAK);
				cmd(CH_C, CH_ZERO, CH_NAK);
				cmd(CH_C, CH_ONE, CH_NAK);
				cmd(CH_C, CH_THREE, CH_NAK);
			end
		check("error", errorSignal, 1'b1);
		rdchk(ADR_LAMP, nShot, "lamp");
		rdchk(ADR_CRYST, nShot, "crystal");
		rdchk(ADR_GOOD, nGood, "good");
		cmd(CH_C, CH_TWO, CH_ACK);
		rdchk(ADR_GOOD, 32'h0, "good");
		@(posedge mclk);
		meth <= METHOD_HOST;
		slow <= 1'b0;
		cmd(CH_C, CH_ONE, CH_ACK);
		rdchk(ADR_LAMP, 32'h0, "lamp");
		rdchk(ADR_CRYST, nShot, "crystal");
		cmd(CH_C, CH_THREE, CH_ACK);
		rdchk(ADR_CRYST, 32'h0, "crystal");
		cmd(CH_C, CH_ZERO, CH_ACK);
		check("error", errorSignal, 1'b0);
		$display("test methods and counters done");
		// Foreign unit and spoilt check character both go unanswered
		host.frame(unit ^ 8'h01, CH_DOLR, CH_ZERO, 1'b0);
		host.frame(unit, CH_DOLR, CH_ZERO, 1'b1);
		repeat (20) @(posedge mclk);
		check("replies", host.reply.size(), 32'h0);
		check("laser", laserEnable, 1'b0);
		cmd(CH_R, CH_R, CH_NAK);
		$display("test framing done");
		// Mix of assigned, unassigned and normal bits
		@(posedge mclk);
		faults <= 64'h8840_8040_0000_6023;
		repeat (2) @(posedge mclk);
		check("error", errorSignal, 1'b1);
		rt_run();
		cmd(CH_C, CH_ZERO, CH_ACK);
		check("error", errorSignal, 1'b1);
		@(posedge mclk);
		faults <= 64'h0;
		rt_run();
		cmd(CH_C, CH_ZERO, CH_ACK);
		check("error", errorSignal, 1'b0);
		$display("test faults done");
		end_of_test();
	end
endmodule
`default_nettype wire
